// ---- hw/gpio_efg_pkg.sv ----
// constants, register map and state types for the port e/f/g block
package gpio_efg_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // port widths and timer channel layout
  localparam int E_W = 8;
  localparam int F_W = 8;
  localparam int G_W = 3;
  localparam int F_CH = 6;
  localparam int ELS_W = 2;
  localparam logic [ELS_W-1:0] ELS_GPIO = 2'h0;

  // register indices; byte address is four times the index
  localparam int IDX_E_LATCH = 'h08;
  localparam int IDX_F_LATCH = 'h09;
  localparam int IDX_G_LATCH = 'h0a;
  localparam int IDX_E_DIR = 'h0c;
  localparam int IDX_F_DIR = 'h0d;
  localparam int IDX_G_DIR = 'h0e;
  localparam int IDX_F_PULLUP = 'h0f;
  localparam int BYTES_PER_REG = 4;

  localparam logic [ADDR_W-1:0] ADDR_E_LATCH =
    ADDR_W'(IDX_E_LATCH * BYTES_PER_REG);
  localparam logic [ADDR_W-1:0] ADDR_F_LATCH =
    ADDR_W'(IDX_F_LATCH * BYTES_PER_REG);
  localparam logic [ADDR_W-1:0] ADDR_G_LATCH =
    ADDR_W'(IDX_G_LATCH * BYTES_PER_REG);
  localparam logic [ADDR_W-1:0] ADDR_E_DIR =
    ADDR_W'(IDX_E_DIR * BYTES_PER_REG);
  localparam logic [ADDR_W-1:0] ADDR_F_DIR =
    ADDR_W'(IDX_F_DIR * BYTES_PER_REG);
  localparam logic [ADDR_W-1:0] ADDR_G_DIR =
    ADDR_W'(IDX_G_DIR * BYTES_PER_REG);
  localparam logic [ADDR_W-1:0] ADDR_F_PULLUP =
    ADDR_W'(IDX_F_PULLUP * BYTES_PER_REG);

  // reset values
  localparam logic [E_W-1:0] E_DIR_RESET = 8'h00;
  localparam logic [F_W-1:0] F_DIR_RESET = 8'h00;
  localparam logic [G_W-1:0] G_DIR_RESET = 3'h0;
  localparam logic [F_W-1:0] F_PULLUP_RESET = 8'h00;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // bus handshake states
  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_RESP = 2'h2
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_RESP = 2'h2
  } rd_state_t;

  // pad drive bundles
  typedef struct packed {
    logic [E_W-1:0] out;
    logic [E_W-1:0] oe;
  } pad8_t;

  typedef struct packed {
    logic [G_W-1:0] out;
    logic [G_W-1:0] oe;
  } pad3_t;

  // whole state of the block
  typedef struct packed {
    wr_state_t wr;
    rd_state_t rd;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wlane;
    logic [E_W-1:0] e_latch;
    logic [F_W-1:0] f_latch;
    logic [G_W-1:0] g_latch;
    logic [E_W-1:0] e_dir;
    logic [F_W-1:0] f_dir;
    logic [G_W-1:0] g_dir;
    logic [F_W-1:0] f_pue;
    logic [E_W+F_W+G_W-1:0] s1;
    logic [E_W+F_W+G_W-1:0] s2;
    logic [E_W+F_W+G_W-1:0] s3;
    logic [E_W+F_W+G_W-1:0] pin;
    pad8_t e_pad;
    pad8_t f_pad;
    pad3_t g_pad;
    logic [F_W-1:0] f_pullup;
    logic [G_W-1:0] keypad;
  } state_t;

endpackage

// ---- hw/gpio_ports_e_f_g.sv ----
// port e, f and g general-purpose i/o with an axi4-lite register slave
`timescale 1ns/1ns

module gpio_ports_e_f_g (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [gpio_efg_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [gpio_efg_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [gpio_efg_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [gpio_efg_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // port e pads and peripheral takeover
  input wire logic [gpio_efg_pkg::E_W-1:0] port_e_pin_in,
  output gpio_efg_pkg::pad8_t port_e_pad,
  input wire logic [gpio_efg_pkg::E_W-1:0] port_e_alt_own,
  input wire logic [gpio_efg_pkg::E_W-1:0] port_e_alt_out,
  input wire logic [gpio_efg_pkg::E_W-1:0] port_e_alt_oe,
  // port f pads, pullups and timer channels
  input wire logic [gpio_efg_pkg::F_W-1:0] port_f_pin_in,
  output gpio_efg_pkg::pad8_t port_f_pad,
  output logic [gpio_efg_pkg::F_W-1:0] port_f_pullup_on,
  input wire logic [gpio_efg_pkg::F_CH*gpio_efg_pkg::ELS_W-1:0]
    edge_level_select,
  input wire logic [gpio_efg_pkg::F_CH-1:0] timer_channel_out,
  input wire logic [gpio_efg_pkg::F_CH-1:0] timer_channel_oe,
  // port g pads and keypad interrupt sharing
  input wire logic [gpio_efg_pkg::G_W-1:0] port_g_pin_in,
  output gpio_efg_pkg::pad3_t port_g_pad,
  input wire logic [gpio_efg_pkg::G_W-1:0] keypad_irq_enable_bit,
  output logic [gpio_efg_pkg::G_W-1:0] keypad_input_pin
);
  import gpio_efg_pkg::*;

  localparam int SYNC_W = E_W + F_W + G_W;

  state_t q;
  state_t d;
  logic [F_CH-1:0] ch_own;
  logic [F_W-1:0] f_own;
  logic [F_W-1:0] f_tim_out;
  logic [F_W-1:0] f_tim_oe;
  logic [E_W-1:0] e_pin;
  logic [F_W-1:0] f_pin;
  logic [G_W-1:0] g_pin;

  // latch where direction is one, filtered pin level where it is zero
  function automatic logic [7:0] readback(input logic [7:0] dir,
                                          input logic [7:0] latch,
                                          input logic [7:0] pin);
    readback = (dir & latch) | (~dir & pin);
  endfunction

  // pins 0..5 carry timer a ch2, ch3, timer b ch2, ch3, ch0, ch1
  for (genvar i = 0; i < F_CH; i++) begin : g_chan
    assign ch_own[i] = edge_level_select[i*ELS_W +: ELS_W] != ELS_GPIO;
  end
  // pins 6 and 7 have no timer channel and stay general purpose
  assign f_own = {{(F_W-F_CH){1'b0}}, ch_own};
  assign f_tim_out = {{(F_W-F_CH){1'b0}}, timer_channel_out};
  assign f_tim_oe = {{(F_W-F_CH){1'b0}}, timer_channel_oe};

  // filtered pin levels split per port
  assign e_pin = q.pin[E_W-1:0];
  assign f_pin = q.pin[E_W+F_W-1:E_W];
  assign g_pin = q.pin[SYNC_W-1:E_W+F_W];

  // next state
  always_comb begin
    d = q;

    // three-stage input capture; a change counts once stages two and
    // three agree, which rejects single-cycle metastable settles
    d.s1 = {port_g_pin_in, port_f_pin_in, port_e_pin_in};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.pin = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.pin);

    // address and data may arrive in either order
    if (awvalid && q.awready) begin
      d.awaddr = awaddr;
      d.awready = 1'b0;
    end
    if (wvalid && q.wready) begin
      d.wdata = wdata[7:0];
      d.wlane = wstrb[0];
      d.wready = 1'b0;
    end

    // write channel
    case (q.wr)
      WR_IDLE: begin
        if (!q.awready && !q.wready) begin
          d.bvalid = 1'b1;
          d.bresp = RESP_OKAY;
          d.wr = WR_RESP;
          case (q.awaddr)
            ADDR_E_LATCH: begin
              if (q.wlane) d.e_latch = q.wdata;
            end
            ADDR_F_LATCH: begin
              if (q.wlane) d.f_latch = q.wdata;
            end
            ADDR_G_LATCH: begin
              if (q.wlane) d.g_latch = q.wdata[G_W-1:0];
            end
            ADDR_E_DIR: begin
              if (q.wlane) d.e_dir = q.wdata;
            end
            ADDR_F_DIR: begin
              if (q.wlane) d.f_dir = q.wdata;
            end
            ADDR_G_DIR: begin
              if (q.wlane) d.g_dir = q.wdata[G_W-1:0];
            end
            ADDR_F_PULLUP: begin
              if (q.wlane) d.f_pue = q.wdata;
            end
            default: begin
              d.bresp = RESP_SLVERR;
            end
          endcase
        end
      end
      WR_RESP: begin
        if (bready) begin
          d.bvalid = 1'b0;
          d.awready = 1'b1;
          d.wready = 1'b1;
          d.wr = WR_IDLE;
        end
      end
      default: begin
        d.wr = WR_IDLE;
      end
    endcase

    // read channel; data reads see the filtered pin, not the raw pad
    case (q.rd)
      RD_IDLE: begin
        if (arvalid) begin
          d.arready = 1'b0;
          d.rvalid = 1'b1;
          d.rresp = RESP_OKAY;
          d.rdata = '0;
          d.rd = RD_RESP;
          case (araddr)
            ADDR_E_LATCH: begin
              d.rdata[E_W-1:0] = readback(q.e_dir, q.e_latch, e_pin);
            end
            ADDR_F_LATCH: begin
              // direction picks readback even for timer pins
              d.rdata[F_W-1:0] = readback(q.f_dir, q.f_latch, f_pin);
            end
            ADDR_G_LATCH: begin
              d.rdata[7:0] = readback({{(8-G_W){1'b0}}, q.g_dir},
                                      {{(8-G_W){1'b0}}, q.g_latch},
                                      {{(8-G_W){1'b0}}, g_pin});
            end
            ADDR_E_DIR: begin
              d.rdata[E_W-1:0] = q.e_dir;
            end
            ADDR_F_DIR: begin
              d.rdata[F_W-1:0] = q.f_dir;
            end
            ADDR_G_DIR: begin
              d.rdata[G_W-1:0] = q.g_dir;
            end
            ADDR_F_PULLUP: begin
              d.rdata[F_W-1:0] = q.f_pue;
            end
            default: begin
              d.rresp = RESP_SLVERR;
            end
          endcase
        end
      end
      RD_RESP: begin
        if (rready) begin
          d.rvalid = 1'b0;
          d.arready = 1'b1;
          d.rd = RD_IDLE;
        end
      end
      default: begin
        d.rd = RD_IDLE;
      end
    endcase

    // port e drive; owning peripheral overrides direction
    d.e_pad.oe = (port_e_alt_own & port_e_alt_oe) |
                 (~port_e_alt_own & q.e_dir);
    d.e_pad.out = (port_e_alt_own & port_e_alt_out) |
                  (~port_e_alt_own & q.e_latch);

    // port f drive; timer channel takes both enable and value
    d.f_pad.oe = (f_own & f_tim_oe) | (~f_own & q.f_dir);
    d.f_pad.out = (f_own & f_tim_out) | (~f_own & q.f_latch);

    // pullup follows direction live, so only a timer-owned output can fight it
    d.f_pullup = q.f_pue & ~q.f_dir;

    // port g drive; keypad enable forces the pin to an input
    d.g_pad.oe = ~keypad_irq_enable_bit & q.g_dir;
    d.g_pad.out = q.g_latch;
    d.keypad = g_pin & keypad_irq_enable_bit;
  end

  // state register; data latches deliberately keep their value on reset
  always_ff @(posedge clock) begin
    q <= d;
    if (!rst_n) begin
      q.wr <= WR_IDLE;
      q.rd <= RD_IDLE;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.bvalid <= 1'b0;
      q.bresp <= RESP_OKAY;
      q.rvalid <= 1'b0;
      q.rresp <= RESP_OKAY;
      q.rdata <= '0;
      q.awaddr <= '0;
      q.wdata <= '0;
      q.wlane <= 1'b0;
      q.e_dir <= E_DIR_RESET;
      q.f_dir <= F_DIR_RESET;
      q.g_dir <= G_DIR_RESET;
      q.f_pue <= F_PULLUP_RESET;
      q.s1 <= '0;
      q.s2 <= '0;
      q.s3 <= '0;
      q.pin <= '0;
      q.e_pad.oe <= '0;
      q.e_pad.out <= '0;
      q.f_pad.oe <= '0;
      q.f_pad.out <= '0;
      q.g_pad.oe <= '0;
      q.g_pad.out <= '0;
      q.f_pullup <= '0;
      q.keypad <= '0;
    end
  end

  // outputs straight from the state register
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign port_e_pad = q.e_pad;
  assign port_f_pad = q.f_pad;
  assign port_f_pullup_on = q.f_pullup;
  assign port_g_pad = q.g_pad;
  assign keypad_input_pin = q.keypad;

endmodule // gpio_ports_e_f_g

// ---- tb/gpio_pins_model.sv ----
// board model around the pads: drivers, pullups and floating pins
`timescale 1ns/1ns
module gpio_pins_model
  import gpio_efg_pkg::*;
(
  // clock for the floating-pin pattern
  input logic clock,
  // pad drive from the block
  input pad8_t e_pad,
  input pad8_t f_pad,
  input pad3_t g_pad,
  input logic [F_W-1:0] pullup_on,
  // board drive and undriven port f pins
  input logic [E_W-1:0] e_ext,
  input logic [F_W-1:0] f_ext,
  input logic [F_W-1:0] f_flt,
  input logic [G_W-1:0] g_ext,
  // pin levels seen by the block
  output logic [E_W-1:0] e_pin,
  output logic [F_W-1:0] f_pin,
  output logic [G_W-1:0] g_pin
);
  logic tog_q = 1'b0;
  // a floating pin without pullup never holds a level
  always_ff @(posedge clock) begin
    tog_q <= ~tog_q;
  end
  // a driven pin shows the block, otherwise the board
  assign e_pin = (e_pad.oe & e_pad.out) | (~e_pad.oe & e_ext);
  assign g_pin = (g_pad.oe & g_pad.out) | (~g_pad.oe & g_ext);
  // pullup only wins where nobody drives
  always_comb begin
    for (int i = 0; i < F_W; i++) begin
      f_pin[i] = f_pad.oe[i] ? f_pad.out[i] :
        f_flt[i] ? (pullup_on[i] | tog_q) : f_ext[i];
    end
  end
endmodule // gpio_pins_model

// ---- tb/gpio_efg_chk.sv ----
// port-level assertions for the port e/f/g block
`timescale 1ns/1ns
module gpio_efg_chk
  import gpio_efg_pkg::*;
(
  // clock, reset and bus
  input logic clock, rst_n, awvalid, awready, wvalid, wready, bvalid,
  input logic arvalid, arready, rvalid, rready,
  input logic [DATA_W-1:0] rdata,
  // pads and takeover inputs
  input pad8_t port_e_pad, port_f_pad,
  input pad3_t port_g_pad,
  input logic [E_W-1:0] port_e_alt_own, port_e_alt_out, port_e_alt_oe,
  input logic [F_W-1:0] port_f_pullup_on,
  input logic [F_CH*ELS_W-1:0] edge_level_select,
  input logic [F_CH-1:0] timer_channel_out, timer_channel_oe,
  input logic [G_W-1:0] keypad_irq_enable_bit
);
  logic [F_CH-1:0] own;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // any nonzero select hands the pin to its channel
  always_comb begin
    for (int i = 0; i < F_CH; i++) begin
      own[i] = |edge_level_select[2*i+:2];
    end
  end
  a_e_alt_drive: assert property ($past(rst_n) |-> ((port_e_pad.oe ^
    $past(port_e_alt_oe)) & $past(port_e_alt_own)) == 8'h00)
    else $error("port e enable not from owner");
  a_e_alt_value: assert property ($past(rst_n) |-> ((port_e_pad.out ^
    $past(port_e_alt_out)) & $past(port_e_alt_own)) == 8'h00)
    else $error("port e value not from owner");
  a_f_timer_oe: assert property ($past(rst_n) |-> ((port_f_pad.oe[5:0] ^
    $past(timer_channel_oe)) & $past(own)) == 6'h00)
    else $error("port f enable not from timer");
  a_f_timer_out: assert property ($past(rst_n) |-> ((port_f_pad.out[5:0] ^
    $past(timer_channel_out)) & $past(own)) == 6'h00)
    else $error("port f value not from timer");
  a_pullup_input: assert property ($past(rst_n) |-> (port_f_pullup_on &
    port_f_pad.oe & ~{2'h0, $past(own)}) == 8'h00)
    else $error("pullup on a driven pin");
  a_keypad_input: assert property ($past(rst_n) |->
    (port_g_pad.oe & $past(keypad_irq_enable_bit)) == 3'h0)
    else $error("keypad pin still driven");
  a_reset_idle: assert property (disable iff (1'b0) !rst_n |=>
    port_e_pad.oe == 8'h00 && port_f_pad.oe == 8'h00 &&
    port_g_pad.oe == 3'h0 && port_f_pullup_on == 8'h00)
    else $error("pads not idle after reset");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_write_answer: assert property (awvalid && awready && wvalid &&
    wready |-> ##2 bvalid)
    else $error("write answer late");
  a_read_hold: assert property (rvalid && !rready |=> rvalid &&
    $stable(rdata))
    else $error("read data dropped");
endmodule // gpio_efg_chk

// ---- tb/tb_gpio_ports_e_f_g.sv ----
// self-checking bench for the port e/f/g block
`timescale 1ns/1ns
module tb_gpio_ports_e_f_g;
  import gpio_efg_pkg::*;
  logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, got;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [E_W-1:0] e_pin, e_own, e_aout, e_aoe, e_ext;
  logic [F_W-1:0] f_pin, f_pu, f_ext, f_flt;
  logic [F_CH*ELS_W-1:0] els;
  logic [F_CH-1:0] t_out, t_oe;
  logic [G_W-1:0] g_pin, g_ext, kb_en, kb_pin;
  pad8_t e_pad, f_pad;
  pad3_t g_pad;
  int miscompares = 0, num_checks = 0, cycles = 0;
  gpio_ports_e_f_g uut (.clock(clock), .rst_n(rst_n), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .port_e_pin_in(e_pin), .port_e_pad(e_pad), .port_e_alt_own(e_own),
    .port_e_alt_out(e_aout), .port_e_alt_oe(e_aoe),
    .port_f_pin_in(f_pin), .port_f_pad(f_pad), .port_f_pullup_on(f_pu),
    .edge_level_select(els), .timer_channel_out(t_out),
    .timer_channel_oe(t_oe), .port_g_pin_in(g_pin), .port_g_pad(g_pad),
    .keypad_irq_enable_bit(kb_en), .keypad_input_pin(kb_pin));
  gpio_pins_model pins (.clock(clock), .e_pad(e_pad), .f_pad(f_pad),
    .g_pad(g_pad), .pullup_on(f_pu), .e_ext(e_ext), .f_ext(f_ext),
    .f_flt(f_flt), .g_ext(g_ext), .e_pin(e_pin), .f_pin(f_pin),
    .g_pin(g_pin));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // cut a hang short, far beyond the roughly 160 cycles needed
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // ready is sampled at the falling edge, so the take is the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clock);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata <= d;
    do @(negedge clock); while (!(awready && wready));
    @(posedge clock);
    {awvalid, wvalid} <= 2'h0;
    do @(negedge clock); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge clock);
    bready <= 1'b0;
    chk({30'h0, resp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clock);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    do @(negedge clock); while (arready !== 1'b1);
    @(posedge clock);
    arvalid <= 1'b0;
    do @(negedge clock); while (rvalid !== 1'b1);
    got = rdata;
    resp = rresp;
    @(posedge clock);
    rready <= 1'b0;
    chk(got, d);
    chk({30'h0, resp}, {30'h0, er});
  endtask
  // pin synchroniser and filter need four edges
  task automatic settle;
    repeat (8) @(posedge clock);
  endtask
  task automatic t_reset;
    rd(ADDR_E_DIR, 32'h0, RESP_OKAY);
    rd(ADDR_F_DIR, 32'h0, RESP_OKAY);
    rd(ADDR_G_DIR, 32'h0, RESP_OKAY);
    rd(ADDR_F_PULLUP, 32'h0, RESP_OKAY);
    chk({24'h0, e_pad.oe}, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_e;
    wr(ADDR_E_LATCH, 32'h3c, RESP_OKAY);
    settle();
    rd(ADDR_E_LATCH, 32'h5a, RESP_OKAY);
    wr(ADDR_E_DIR, 32'hf0, RESP_OKAY);
    settle();
    chk({24'h0, e_pad.oe}, 32'hf0);
    chk({28'h0, e_pad.out[7:4]}, 32'h3);
    rd(ADDR_E_LATCH, 32'h3a, RESP_OKAY);
    e_own <= 8'h81;
    e_aoe <= 8'h01;
    e_aout <= 8'h81;
    settle();
    chk({24'h0, e_pad.oe}, 32'h71);
    rd(ADDR_E_LATCH, 32'h3b, RESP_OKAY);
    e_own <= 8'h00;
    $display("port e test done");
  endtask
  task automatic t_f;
    f_flt <= 8'hf0;
    wr(ADDR_F_PULLUP, 32'hff, RESP_OKAY);
    wr(ADDR_F_LATCH, 32'h0f, RESP_OKAY);
    wr(ADDR_F_DIR, 32'h0f, RESP_OKAY);
    settle();
    chk({24'h0, f_pu}, 32'hf0);
    chk({24'h0, f_pad.oe}, 32'h0f);
    rd(ADDR_F_DIR, 32'h0f, RESP_OKAY);
    rd(ADDR_F_LATCH, 32'hff, RESP_OKAY);
    wr(ADDR_F_PULLUP, 32'h0f, RESP_OKAY);
    f_flt <= 8'h00;
    els <= 12'hc01;
    t_oe <= 6'h20;
    settle();
    chk({24'h0, f_pu}, 32'h0);
    chk({24'h0, f_pad.oe}, 32'h2e);
    rd(ADDR_F_LATCH, 32'haf, RESP_OKAY);
    els <= 12'h000;
    $display("port f test done");
  endtask
  task automatic t_g;
    wr(ADDR_G_LATCH, 32'h2, RESP_OKAY);
    wr(ADDR_G_DIR, 32'h3, RESP_OKAY);
    settle();
    chk({29'h0, g_pad.oe}, 32'h3);
    chk({29'h0, g_pad.out}, 32'h2);
    rd(ADDR_G_LATCH, 32'h6, RESP_OKAY);
    kb_en <= 3'h1;
    settle();
    chk({29'h0, g_pad.oe}, 32'h2);
    chk({29'h0, kb_pin}, 32'h1);
    $display("port g test done");
  endtask
  task automatic t_keep;
    wr(8'h00, 32'h1, RESP_SLVERR);
    rd(8'h00, 32'h0, RESP_SLVERR);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(ADDR_F_DIR, 32'h0, RESP_OKAY);
    rd(ADDR_G_DIR, 32'h0, RESP_OKAY);
    wr(ADDR_F_DIR, 32'hff, RESP_OKAY);
    rd(ADDR_F_LATCH, 32'h0f, RESP_OKAY);
    wr(ADDR_G_DIR, 32'h7, RESP_OKAY);
    // a write with its low lane off is answered but must not land
    wstrb <= 4'h0;
    wr(ADDR_G_LATCH, 32'h5, RESP_OKAY);
    wstrb <= 4'h1;
    rd(ADDR_G_LATCH, 32'h2, RESP_OKAY);
    $display("reset keep test done");
  endtask
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'h1};
    {e_own, e_aout, e_aoe, els, t_out, t_oe, kb_en} = '0;
    {e_ext, f_ext, f_flt, g_ext} = {8'h5a, 8'ha5, 8'h00, 3'h5};
    t_out = 6'h3f;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_e();
    t_f();
    t_g();
    t_keep();
    close_out();
  end
endmodule // tb_gpio_ports_e_f_g
bind gpio_ports_e_f_g gpio_efg_chk chk (.clock(clock), .rst_n(rst_n),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .port_e_pad(port_e_pad),
  .port_f_pad(port_f_pad), .port_g_pad(port_g_pad),
  .port_e_alt_own(port_e_alt_own), .port_e_alt_out(port_e_alt_out),
  .port_e_alt_oe(port_e_alt_oe), .port_f_pullup_on(port_f_pullup_on),
  .edge_level_select(edge_level_select),
  .timer_channel_out(timer_channel_out), .timer_channel_oe(timer_channel_oe),
  .keypad_irq_enable_bit(keypad_irq_enable_bit));
